// ---- src/ref_input_pkg.sv ----
// constants for the reference input stage and loss-of-signal monitor
// Notes on behaviour
// R1 - stage is one differential, two single-ended, or differential plus pin input
// R2 - differential-only mode: internal index equals the pin pair index
// R3 - differential inputs above 150MHz divided by an integer 2..65536
// R4 - divider may be bypassed when the reference is below 150MHz
// R5 - differential edge chosen by feeding true or inverted path to divider
// R6 - dual single-ended: positive pin takes index, negative pin index plus 8
// R7 - single-ended paths each have their own divider
// R8 - rising or falling edge selectable per path
// R9 - buffer polarity-type select has no effect on single-ended or pin inputs
// R10 - mixed mode only on listed stages; pin 0 maps to 8, pin 3 to 15
// R11 - pin inputs limited to 150MHz and never divided
// R12 - each unused input can be disabled
// R13 - any input may serve as sync or frame pulse for another input
// R14 - software programs nominal frequency before an input is used
// R15 - every input monitored continuously for loss of signal
// R16 - monitor failure raises alarm; alarmed input excluded unless forced qualified
// R17 - normal monitoring chooses tight or loose edge tolerance
// R18 - above 500kHz both tolerances use plus or minus 20 ns
// R19 - at or below 500kHz loose is 25 percent, tight 1 percent
// R20 - gapped mode: loss after configured consecutive misses, cleared on next edge
// R21 - gap setting 00 off, 01 one, 10 two, 11 five; 01 acts normal (code treats 01 as gapped, so early edges raise no alarm)
// R22 - alarm starts a timer; disqualify only if alarm lasts the whole time
// R23 - expected edge positions computed from nominal frequency on system clock
package ref_input_pkg;
	localparam int unsigned clock_hz        = 50_000_000;
	localparam int unsigned clock_period_ns = 20;
	localparam int unsigned edge_window_ns  = 20;
	localparam int unsigned edge_window_cyc =
		(edge_window_ns / clock_period_ns) < 1 ? 1 : edge_window_ns / clock_period_ns;
	localparam int unsigned low_freq_hz     = 500_000;
	localparam int unsigned max_loop_hz     = 150_000_000;
	localparam int unsigned loose_pct       = 25;
	localparam int unsigned tight_pct       = 1;
	localparam int unsigned pct_base        = 100;
	localparam int unsigned dsq_default_cyc = 125_000_000;
	localparam int unsigned num_stages      = 2;
	localparam int unsigned num_refs        = 16;
	localparam int unsigned neg_index_step  = 8;
	localparam int unsigned pin0_index      = 8;
	localparam int unsigned pin3_index      = 15;
	localparam int unsigned idx_w           = 4;
	localparam int unsigned div_w           = 16;
	localparam int unsigned period_w        = 24;
	localparam int unsigned freq_w          = 32;

	// register byte addresses, per stage block of stage_stride, then the global status and disqualify timer registers
	localparam logic [11:0] stage_stride    = 12'h020;
	localparam logic [11:0] reg_stage_mode  = 12'h000;
	localparam logic [11:0] reg_stage_div_p = 12'h004;
	localparam logic [11:0] reg_stage_div_n = 12'h008;
	localparam logic [11:0] reg_stage_freq  = 12'h00c;
	localparam logic [11:0] reg_los_cfg_p   = 12'h010;
	localparam logic [11:0] reg_los_cfg_n   = 12'h014;
	localparam logic [11:0] reg_status      = 12'h100;
	localparam logic [11:0] reg_dsq_timer   = 12'h104;

	// mode register fields
	localparam int unsigned f_mode_lo       = 0;
	localparam int unsigned f_inv_p         = 2;
	localparam int unsigned f_inv_n         = 3;
	localparam int unsigned f_byp_p         = 4;
	localparam int unsigned f_byp_n         = 5;
	localparam int unsigned f_pmos          = 6;
	localparam int unsigned f_dis_p         = 7;
	localparam int unsigned f_dis_n         = 8;
	localparam int unsigned f_sync_p        = 9;
	localparam int unsigned f_sync_n        = 10;
	// los config fields
	localparam int unsigned f_tight         = 0;
	localparam int unsigned f_gap_lo        = 1;
	localparam int unsigned f_qual_force    = 3;

	localparam logic [1:0] gap_off  = 2'h0;
	localparam logic [1:0] gap_one  = 2'h1;
	localparam logic [1:0] gap_two  = 2'h2;
	localparam logic [1:0] gap_five = 2'h3;
	localparam logic [2:0] miss_one  = 3'h1;
	localparam logic [2:0] miss_two  = 3'h2;
	localparam logic [2:0] miss_five = 3'h5;

	typedef enum logic [1:0] {
		mode_diff,
		mode_dual_se,
		mode_diff_pin
	} stage_mode_e;
endpackage

// ---- src/los_channel.sv ----
// one reference path: edge select, pre-divider, loss-of-signal and disqualify timer
`timescale 1ns/10ps
`default_nettype none
module los_channel (
	input  wire logic                                 clock,
	input  wire logic                                 reset,
	input  wire logic                                 clk_en,
	input  wire logic                                 ref_in,
	input  wire logic                                 enable,
	input  wire logic                                 invert,
	input  wire logic                                 bypass,
	input  wire logic                                 no_divide,
	input  wire logic [ref_input_pkg::div_w-1:0]      div_m1,
	input  wire logic [ref_input_pkg::freq_w-1:0]     nominal_hz,
	input  wire logic                                 tight,
	input  wire logic [1:0]                           gap_sel,
	input  wire logic                                 force_qual,
	input  wire logic [31:0]                          dsq_cycles,
	output logic                                      loop_edge,
	output logic                                      los,
	output logic                                      qualified
);
	logic                                  ref_d_r;
	logic [ref_input_pkg::div_w-1:0]       div_cnt_r;
	logic [ref_input_pkg::period_w-1:0]    since_r;
	logic [2:0]                            miss_r;
	logic                                  los_r;
	logic [31:0]                           dsq_cnt_r;
	logic                                  dsq_r;
	logic [ref_input_pkg::period_w-1:0]    period_cyc;
	logic [ref_input_pkg::period_w-1:0]    tol_cyc;
	logic [ref_input_pkg::period_w-1:0]    late_lim;
	logic [2:0]                            miss_lim;
	wire  sel_in   = ref_in ^ invert; // R5 R8
	wire  in_edge  = clk_en & enable & sel_in & ~ref_d_r; // no edge reported while frozen
	wire  div_wrap = (div_cnt_r == div_m1);
	wire  out_edge = in_edge & (bypass | no_divide | div_wrap); // R3 R4 R7 R11
	// since_r lags the edge interval by one cycle
	wire  early    = out_edge & (since_r + tol_cyc + 1'b1 < period_cyc) & ~los_r;
	wire  late     = since_r >= late_lim;
	wire  gapped   = gap_sel != ref_input_pkg::gap_off;

	// R23: period and tolerance from the programmed nominal frequency
	always_comb begin
		period_cyc = (nominal_hz == '0) ? '1 :
			ref_input_pkg::period_w'(64'(ref_input_pkg::clock_hz) / 64'(nominal_hz));
		if (nominal_hz > ref_input_pkg::low_freq_hz) begin
			tol_cyc = ref_input_pkg::period_w'(ref_input_pkg::edge_window_cyc); // R18
		end else if (tight) begin
			tol_cyc = ref_input_pkg::period_w'(period_cyc * ref_input_pkg::tight_pct
				/ ref_input_pkg::pct_base); // R17 R19
		end else begin
			tol_cyc = ref_input_pkg::period_w'(period_cyc * ref_input_pkg::loose_pct
				/ ref_input_pkg::pct_base); // R17 R19
		end
		late_lim = period_cyc + tol_cyc;
		case (gap_sel)
			ref_input_pkg::gap_two:  miss_lim = ref_input_pkg::miss_two;
			ref_input_pkg::gap_five: miss_lim = ref_input_pkg::miss_five;
			default:                 miss_lim = ref_input_pkg::miss_one; // R21
		endcase
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ref_d_r   <= 1'b0;
			div_cnt_r <= '0;
		end else if (clk_en) begin
			ref_d_r <= sel_in;
			if (in_edge) begin
				div_cnt_r <= div_wrap ? '0 : div_cnt_r + 1'b1;
			end
		end
	end

	// R15 R20: counts cycles since the last divided edge; misses counted per period
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			since_r <= '0;
			miss_r  <= '0;
			los_r   <= 1'b0;
		end else if (clk_en) begin
			if (!enable) begin
				since_r <= '0;
				miss_r  <= '0;
				los_r   <= 1'b0; // R12
			end else if (out_edge) begin
				since_r <= '0;
				miss_r  <= '0;
				los_r   <= early & ~gapped;
			end else if (late) begin
				since_r <= tol_cyc; // next miss is one full period later
				if (miss_r + 3'h1 >= miss_lim) begin
					los_r <= 1'b1; // R20
				end else begin
					miss_r <= miss_r + 3'h1;
				end
			end else begin
				since_r <= since_r + 1'b1;
			end
		end
	end

	// R22: disqualify only after the alarm persists for the full timer
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			dsq_cnt_r <= '0;
			dsq_r     <= 1'b0;
		end else if (clk_en) begin
			if (!los_r) begin
				dsq_cnt_r <= '0;
				dsq_r     <= 1'b0;
			end else if (dsq_cnt_r >= dsq_cycles) begin
				dsq_r <= 1'b1;
			end else begin
				dsq_cnt_r <= dsq_cnt_r + 32'h1;
			end
		end
	end

	assign loop_edge = out_edge;
	assign los       = los_r;
	assign qualified = enable & (~dsq_r | force_qual); // R16

	chk_los_clears: assert property (@(posedge clock) disable iff (reset) // R20
		clk_en && enable && out_edge && gapped |=> !los) else $error("gapped los not cleared");
	chk_dsq_needs_los: assert property (@(posedge clock) disable iff (reset) // R22
		clk_en && !los_r |=> !dsq_r) else $error("disqualified without alarm");
	chk_disabled_quiet: assert property (@(posedge clock) disable iff (reset) // R12
		!enable |-> !loop_edge && !qualified) else $error("disabled input active");
endmodule
`default_nettype wire

// ---- src/ref_input_stage_los_monitor.sv ----
// input stages with apb registers, index mapping and per-path los monitors
`timescale 1ns/10ps
`default_nettype none
module ref_input_stage_los_monitor (
	input  wire logic                                     clock,
	input  wire logic                                     reset,
	input  wire logic                                     clk_en,
	input  wire logic                                     psel,
	input  wire logic                                     penable,
	input  wire logic                                     pwrite,
	input  wire logic [11:0]                              paddr,
	input  wire logic [31:0]                              pwdata,
	output logic      [31:0]                              prdata,
	output logic                                          pready,
	output logic                                          pslverr,
	input  wire logic [ref_input_pkg::num_stages-1:0]     pin_p,
	input  wire logic [ref_input_pkg::num_stages-1:0]     pin_n,
	input  wire logic                                     gpio_ref0,
	input  wire logic                                     gpio_ref3,
	output logic      [ref_input_pkg::num_refs-1:0]       ref_edge,
	output logic      [ref_input_pkg::num_refs-1:0]       ref_los,
	output logic      [ref_input_pkg::num_refs-1:0]       ref_usable,
	output logic      [ref_input_pkg::num_refs-1:0]       ref_is_sync,
	output logic      [ref_input_pkg::num_refs-1:0]       buf_pmos
);
	localparam int unsigned np = 2 * ref_input_pkg::num_stages;
	logic [31:0] mode_r  [ref_input_pkg::num_stages];
	logic [31:0] div_r   [np];
	logic [31:0] freq_r  [ref_input_pkg::num_stages];
	logic [31:0] los_r   [np];
	logic [31:0] dsq_r;
	logic [31:0] rdata_r;
	logic        err_r;
	logic [np-1:0] p_edge, p_los, p_qual, p_in, p_en, p_noddiv;
	logic [ref_input_pkg::num_refs-1:0] edge_map, los_map, use_map, sync_map, pmos_map;

	wire        acc       = psel & penable;
	wire [11:0] stage_off = paddr & (ref_input_pkg::stage_stride - 12'h001);
	wire        stage_sel = paddr[11:5] == 7'h00 || paddr[11:5] == 7'h01;
	wire        sidx      = paddr[5];
	wire        hit_glob  = paddr == ref_input_pkg::reg_status || paddr == ref_input_pkg::reg_dsq_timer;
	wire        hit_stage = stage_sel && stage_off <= ref_input_pkg::reg_los_cfg_n && stage_off[1:0] == 2'h0;
	wire        bad       = ~(hit_glob | hit_stage);

	function automatic logic [1:0] mode_of(input logic [31:0] m, input int s);
		logic [1:0] v;
		v = m[ref_input_pkg::f_mode_lo +: 2];
		// R10: mixed mode only where a pin input exists; otherwise treated as differential
		if (v == 2'(ref_input_pkg::mode_diff_pin) && s >= ref_input_pkg::num_stages) begin
			v = 2'(ref_input_pkg::mode_diff);
		end
		return v;
	endfunction

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < ref_input_pkg::num_stages; i++) begin
				mode_r[i] <= '0;
				freq_r[i] <= '0;
			end
			for (int i = 0; i < np; i++) begin
				div_r[i] <= '0;
				los_r[i] <= '0; // R21 gap off by default
			end
			dsq_r <= ref_input_pkg::dsq_default_cyc;
		end else if (clk_en && acc && pwrite && !bad) begin
			// global offsets alias stage offsets in their low bits, so they decode first
			if (paddr == ref_input_pkg::reg_dsq_timer) begin
				dsq_r <= pwdata;
			end else if (hit_stage) begin
				case (stage_off)
					ref_input_pkg::reg_stage_mode:  mode_r[sidx] <= pwdata;
					ref_input_pkg::reg_stage_div_p: div_r[2*sidx] <= pwdata;
					ref_input_pkg::reg_stage_div_n: div_r[2*sidx+1] <= pwdata;
					ref_input_pkg::reg_stage_freq:  freq_r[sidx] <= pwdata; // R14
					ref_input_pkg::reg_los_cfg_p:   los_r[2*sidx] <= pwdata;
					ref_input_pkg::reg_los_cfg_n:   los_r[2*sidx+1] <= pwdata;
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rdata_r <= '0;
			err_r   <= 1'b0;
		end else if (clk_en && psel && !penable) begin
			err_r <= bad;
			if (paddr == ref_input_pkg::reg_status) begin
				rdata_r <= {24'h0, p_qual, p_los};
			end else if (paddr == ref_input_pkg::reg_dsq_timer) begin
				rdata_r <= dsq_r;
			end else if (bad) begin
				rdata_r <= '0;
			end else begin
				case (stage_off)
					ref_input_pkg::reg_stage_mode:  rdata_r <= mode_r[sidx];
					ref_input_pkg::reg_stage_div_p: rdata_r <= div_r[2*sidx];
					ref_input_pkg::reg_stage_div_n: rdata_r <= div_r[2*sidx+1];
					ref_input_pkg::reg_stage_freq:  rdata_r <= freq_r[sidx];
					ref_input_pkg::reg_los_cfg_p:   rdata_r <= los_r[2*sidx];
					default:                        rdata_r <= los_r[2*sidx+1];
				endcase
			end
		end
	end

	assign prdata  = rdata_r;
	assign pready  = 1'b1;
	assign pslverr = acc & err_r;

	genvar g;
	generate
		for (g = 0; g < ref_input_pkg::num_stages; g++) begin : stg
			wire [1:0] md  = mode_of(mode_r[g], g);
			wire       dif = md == 2'(ref_input_pkg::mode_diff);
			wire       mix = md == 2'(ref_input_pkg::mode_diff_pin);
			wire       gp  = (g == 0) ? gpio_ref0 : gpio_ref3;
			// R1: differential path sees p minus n; dual mode uses each pin alone
			assign p_in[2*g]       = (dif | mix) ? (pin_p[g] & ~pin_n[g]) : pin_p[g];
			assign p_in[2*g+1]     = mix ? gp : pin_n[g];
			assign p_en[2*g]       = ~mode_r[g][ref_input_pkg::f_dis_p]; // R12
			assign p_en[2*g+1]     = ~dif & ~mode_r[g][ref_input_pkg::f_dis_n]; // R12
			assign p_noddiv[2*g]   = 1'b0;
			assign p_noddiv[2*g+1] = mix; // R11
		end
		for (g = 0; g < np; g++) begin : ch
			los_channel u_ch (
				.clock      (clock),
				.reset      (reset),
				.clk_en     (clk_en),
				.ref_in     (p_in[g]),
				.enable     (p_en[g]),
				.invert     (mode_r[g/2][ref_input_pkg::f_inv_p + g%2]), // R5 R8
				.bypass     (mode_r[g/2][ref_input_pkg::f_byp_p + g%2]), // R4
				.no_divide  (p_noddiv[g]),
				.div_m1     (ref_input_pkg::div_w'(div_r[g])), // R3 R7 value is divisor minus one
				.nominal_hz (freq_r[g/2]),
				.tight      (los_r[g][ref_input_pkg::f_tight]),
				.gap_sel    (los_r[g][ref_input_pkg::f_gap_lo +: 2]),
				.force_qual (los_r[g][ref_input_pkg::f_qual_force]),
				.dsq_cycles (dsq_r),
				.loop_edge  (p_edge[g]),
				.los        (p_los[g]),
				.qualified  (p_qual[g])
			);
		end
	endgenerate

	// index mapping onto the sixteen internal references
	always_comb begin
		edge_map = '0;
		los_map  = '0;
		use_map  = '0;
		sync_map = '0;
		pmos_map = '0;
		for (int s = 0; s < ref_input_pkg::num_stages; s++) begin
			int ni;
			ni = (s == 0) ? ref_input_pkg::pin0_index :
				(mode_of(mode_r[s], s) == 2'(ref_input_pkg::mode_diff_pin)) ?
				ref_input_pkg::pin3_index : s + ref_input_pkg::neg_index_step; // R6 R10
			edge_map[s]  = p_edge[2*s]; // R2
			los_map[s]   = p_los[2*s];
			sync_map[s]  = mode_r[s][ref_input_pkg::f_sync_p]; // R13
			use_map[s]   = p_qual[2*s] & ~mode_r[s][ref_input_pkg::f_sync_p]; // R16
			pmos_map[s]  = mode_of(mode_r[s], s) != 2'(ref_input_pkg::mode_dual_se) &
				mode_r[s][ref_input_pkg::f_pmos]; // R9
			edge_map[ni] = p_edge[2*s+1];
			los_map[ni]  = p_los[2*s+1];
			sync_map[ni] = mode_r[s][ref_input_pkg::f_sync_n];
			use_map[ni]  = p_qual[2*s+1] & ~mode_r[s][ref_input_pkg::f_sync_n];
		end
	end

	assign ref_edge    = edge_map;
	assign ref_los     = los_map;
	assign ref_usable  = use_map;
	assign ref_is_sync = sync_map;
	assign buf_pmos    = pmos_map;

	chk_apb_noerr: assert property (@(posedge clock) disable iff (reset)
		clk_en && psel && !penable && !bad ##1 psel && penable |-> !pslverr)
		else $error("error on mapped address");
	chk_pmos_se: assert property (@(posedge clock) disable iff (reset) // R9
		mode_r[0][1:0] == 2'(ref_input_pkg::mode_dual_se) |-> !buf_pmos[0])
		else $error("pmos applied to single ended");
	chk_sync_unusable: assert property (@(posedge clock) disable iff (reset) // R13 R16
		(ref_is_sync & ref_usable) == 16'h0000) else $error("sync input offered as reference");
endmodule
`default_nettype wire

// ---- bench/ref_clock_source.sv ----
// reference clock source model standing in for the external clock drivers
`timescale 1ns/10ps
`default_nettype none
module ref_clock_source #(
	parameter int unsigned half = 4
) (
	input  wire logic clock,
	input  wire logic run_p,
	input  wire logic run_n,
	input  wire logic diff,
	output logic      p,
	output logic      n
);
	int unsigned cnt_p = 0;
	int unsigned cnt_n = half / 2;
	logic        n_own = 1'h0;
	initial p = 1'h0;
	// a stopped clock stands still at its last level, as a dead driver would
	always @(posedge clock) begin
		if (run_p) begin
			cnt_p <= (cnt_p == half - 1) ? 0 : cnt_p + 1;
			if (cnt_p == half - 1)
				p <= ~p;
		end
		if (run_n) begin
			cnt_n <= (cnt_n == half - 1) ? 0 : cnt_n + 1;
			if (cnt_n == half - 1)
				n_own <= ~n_own;
		end
	end
	// differential drive is the exact complement; single-ended runs offset in phase
	assign n = diff ? ~p : n_own;
endmodule
`default_nettype wire

// ---- bench/ref_input_stage_los_monitor_tb.sv ----
// self-checking bench for the reference input stages and loss-of-signal monitors
`timescale 1ns/10ps
`default_nettype none
module ref_input_stage_los_monitor_tb;
	typedef struct {logic [11:0] base; logic [31:0] mode; int ia; int ib; logic ea; logic eb; logic ep;} row_s;
	logic        clock;
	logic        reset;
	logic        clk_en;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  pin_p;
	logic [1:0]  pin_n;
	logic        gpio_ref0;
	logic        gpio_ref3;
	logic [15:0] ref_edge;
	logic [15:0] ref_los;
	logic [15:0] ref_usable;
	logic [15:0] ref_is_sync;
	logic [15:0] buf_pmos;
	logic        run_p0;
	logic        diff_sel;
	logic [31:0] rd;
	logic        err;
	int          na;
	int          nb;
	int          cycles;
	int          failures;
	int          checked;
	row_s        rows[7];
	logic [31:0] lcfg[5] = '{32'h0, 32'h1, 32'h2, 32'h4, 32'h6};
	int          lmiss[5] = '{1, 1, 1, 2, 5};

	ref_input_stage_los_monitor i_ref_input_stage_los_monitor (.clock(clock), .reset(reset), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_p(pin_p), .pin_n(pin_n), .gpio_ref0(gpio_ref0),
		.gpio_ref3(gpio_ref3), .ref_edge(ref_edge), .ref_los(ref_los), .ref_usable(ref_usable),
		.ref_is_sync(ref_is_sync), .buf_pmos(buf_pmos));
	ref_clock_source i_ref_clock_source_0 (.clock(clock), .run_p(run_p0), .run_n(1'h1), .diff(diff_sel),
		.p(pin_p[0]), .n(pin_n[0]));
	ref_clock_source i_ref_clock_source_1 (.clock(clock), .run_p(1'h1), .run_n(1'h1), .diff(1'h1),
		.p(pin_p[1]), .n(pin_n[1]));
	// pin-input sources stop together with the stage 0 positive source
	ref_clock_source i_ref_clock_source_g (.clock(clock), .run_p(run_p0), .run_n(run_p0), .diff(1'h0),
		.p(gpio_ref0), .n(gpio_ref3));

	initial begin
		clock = 1'h0;
		forever #10 clock = ~clock;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
			failures++;
		end
	endtask

	task automatic test_done;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// one apb transfer, entered just after a rising edge, leaves one idle edge behind
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		@(posedge clock);
		while (pready !== 1'h1) begin
			@(posedge clock);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clock);
	endtask

	task automatic count_edges(input int a, input int b, output int ca, output int cb);
		ca = 0;
		cb = 0;
		repeat (16) @(posedge clock);
		repeat (160) begin
			@(posedge clock);
			if (ref_edge[a] === 1'h1) ca++;
			if (ref_edge[b] === 1'h1) cb++;
		end
	endtask

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			test_done();
		end
	end

	initial begin
		reset = 1'h1;
		clk_en = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		run_p0 = 1'h1;
		diff_sel = 1'h1;
		cycles = 0;
		failures = 0;
		checked = 0;
		rows = '{'{12'h000, 32'h070, 0, 8, 1'h1, 1'h0, 1'h1}, '{12'h000, 32'h071, 0, 8, 1'h1, 1'h1, 1'h0},
			'{12'h000, 32'h072, 0, 8, 1'h1, 1'h1, 1'h1}, '{12'h000, 32'h0b1, 0, 8, 1'h0, 1'h1, 1'h0},
			'{12'h000, 32'h131, 0, 8, 1'h1, 1'h0, 1'h0}, '{12'h000, 32'h231, 0, 8, 1'h1, 1'h1, 1'h0},
			'{12'h020, 32'h072, 1, 15, 1'h1, 1'h1, 1'h1}};
		repeat (6) @(posedge clock);
		reset <= 1'h0;
		@(posedge clock);
		apb(1'h0, 12'h104, 32'h0, rd, err);
		check(rd, 32'h07735940);
		apb(1'h0, 12'h0f0, 32'h0, rd, err);
		check(rd, 32'h0);
		check(err, 1'h1);
		apb(1'h1, 12'h00c, 32'h005f5e10, rd, err);
		apb(1'h1, 12'h02c, 32'h005f5e10, rd, err);
		$display("reset and map test done");
		for (int i = 0; i < 7; i++) begin
			diff_sel <= (rows[i].mode[1:0] != 2'h1);
			apb(1'h1, rows[i].base, rows[i].mode, rd, err);
			apb(1'h0, rows[i].base, 32'h0, rd, err);
			check(rd, rows[i].mode);
			count_edges(rows[i].ia, rows[i].ib, na, nb);
			check(rows[i].ea ? na >= 15 : na == 0, 1'h1);
			check(rows[i].eb ? nb >= 15 : nb == 0, 1'h1);
			check(buf_pmos[rows[i].ia], rows[i].ep);
			check(buf_pmos[rows[i].ib], 1'h0);
			check(ref_is_sync[rows[i].ia], rows[i].mode[9]);
			check(ref_usable[rows[i].ia] & rows[i].mode[9], 1'h0);
			$display("mode row %0d done", i);
		end
		// divide by four on the positive path, by two on the negative one
		diff_sel <= 1'h0;
		apb(1'h1, 12'h004, 32'h3, rd, err);
		apb(1'h1, 12'h008, 32'h1, rd, err);
		apb(1'h1, 12'h000, 32'h1, rd, err);
		count_edges(0, 8, na, nb);
		check(na >= 4 && na <= 6, 1'h1);
		check(nb >= 9 && nb <= 11, 1'h1);
		apb(1'h1, 12'h000, 32'h2, rd, err);
		diff_sel <= 1'h1;
		count_edges(0, 8, na, nb);
		check(na >= 4 && na <= 6, 1'h1);
		check(nb >= 19 && nb <= 21, 1'h1);
		// inverted positive path: the loop edge follows a falling pin edge
		apb(1'h1, 12'h000, 32'h35, rd, err);
		repeat (16) @(posedge clock);
		while (ref_edge[0] !== 1'h1) begin
			@(posedge clock);
		end
		check(pin_p[0], 1'h0);
		$display("divider test done");
		diff_sel <= 1'h0;
		apb(1'h1, 12'h000, 32'h31, rd, err);
		for (int i = 0; i < 5; i++) begin
			apb(1'h1, 12'h010, lcfg[i], rd, err);
			run_p0 <= 1'h1;
			repeat (40) @(posedge clock);
			check(ref_los[0], 1'h0);
			run_p0 <= 1'h0;
			if (lmiss[i] > 1) begin
				repeat ((lmiss[i] - 2) * 8) @(posedge clock);
				check(ref_los[0], 1'h0);
			end
			repeat (lmiss[i] > 1 ? 32 : 24) @(posedge clock);
			check(ref_los[0], 1'h1);
			run_p0 <= 1'h1;
			repeat (20) @(posedge clock);
			if (lcfg[i][2:1] != 2'h0)
				check(ref_los[0], 1'h0);
			$display("los setting %0d done", i);
		end
		// short disqualify time so the timer can be watched running out
		apb(1'h1, 12'h104, 32'h64, rd, err);
		apb(1'h1, 12'h010, 32'h0, rd, err);
		repeat (40) @(posedge clock);
		run_p0 <= 1'h0;
		na = 0;
		while (ref_los[0] !== 1'h1 && na < 100) begin
			@(posedge clock);
			na++;
		end
		repeat (50) @(posedge clock);
		check(ref_usable[0], 1'h1);
		repeat (100) @(posedge clock);
		check(ref_usable[0], 1'h0);
		apb(1'h1, 12'h010, 32'h8, rd, err);
		repeat (4) @(posedge clock);
		check({ref_los[0], ref_usable[0]}, 2'h3);
		$display("disqualify test done");
		// frozen clock enable: pins run on, no edge is seen and los holds
		run_p0 <= 1'h1;
		clk_en <= 1'h0;
		count_edges(0, 8, na, nb);
		check(na == 0 && nb == 0, 1'h1);
		check(ref_los[0], 1'h1);
		clk_en <= 1'h1;
		repeat (20) @(posedge clock);
		check(ref_los[0], 1'h0);
		reset <= 1'h1;
		repeat (2) @(posedge clock);
		check(ref_los, 16'h0);
		check(ref_usable, 16'h0003);
		reset <= 1'h0;
		@(posedge clock);
		apb(1'h0, 12'h010, 32'h0, rd, err);
		check(rd, 32'h0);
		apb(1'h0, 12'h104, 32'h0, rd, err);
		check(rd, 32'h07735940);
		$display("freeze and reset test done");
		test_done();
	end
endmodule
`default_nettype wire
